// *** shared/rpcf_regs.vh ***
// Register offsets, field positions and encodings of the root pointer and context flush block.
`ifndef RPCF_REGS_VH
`define RPCF_REGS_VH

// Byte offsets of the 32-bit register words.
`define RPCF_RTP_LO_OFS    8'h20
`define RPCF_RTP_HI_OFS    8'h24
`define RPCF_CFC_LO_OFS    8'h28
`define RPCF_CFC_HI_OFS    8'h2c
`define RPCF_GCMD_OFS      8'h30
`define RPCF_GSTS_OFS      8'h34

// Root table pointer fields, as positions within the 64-bit register.
`define RPCF_RTP_BASE_LSB  12
`define RPCF_RTP_FMT_BIT   11

// Context flush command fields, as positions within the upper word.
`define RPCF_CFC_REQ_BIT   31
`define RPCF_CFC_RSC_MSB   30
`define RPCF_CFC_RSC_LSB   29
`define RPCF_CFC_PSC_MSB   28
`define RPCF_CFC_PSC_LSB   27
`define RPCF_CFC_FMS_MSB   1
`define RPCF_CFC_FMS_LSB   0

// Context flush command fields within the lower word.
`define RPCF_CFC_RID_MSB   31
`define RPCF_CFC_RID_LSB   16
`define RPCF_CFC_DOM_MSB   15
`define RPCF_CFC_DOM_LSB   0

// Global command and status bit positions.
`define RPCF_GCMD_LATCH_BIT 30
`define RPCF_GSTS_LATCH_BIT 30

// Flush scope encodings.
`define RPCF_SCOPE_RSVD    2'h0
`define RPCF_SCOPE_GLOBAL  2'h1
`define RPCF_SCOPE_DOMAIN  2'h2
`define RPCF_SCOPE_DEVICE  2'h3

// Reset values.
`define RPCF_ZERO32        32'h00000000
`define RPCF_ZERO2         2'h0

`endif

// *** core/rpcf_sync2.v ***
// Two flip-flop synchroniser for single-bit inputs from outside the clock domain.
`timescale 1ns/10ps
module rpcf_sync2 #(
  parameter W = 1                     // Number of bits.
) (
  input  wire         clk_i,          // Clock.
  input  wire         rst_n_i,        // Asynchronous reset, active low.
  input  wire [W-1:0] d_i,            // Asynchronous input.
  output wire [W-1:0] q_o             // Synchronised output.
);

  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // The first stage feeds only the second stage.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end

  assign q_o = sync_r;

endmodule // rpcf_sync2

// *** core/rpcf_regbank.v ***
// Root table pointer and context flush command register bank.
//
// Overview of operation
// - Base bits 63:12 name a 4KB table; reads return the stored bits of the last value written.
// - Base bits at and above the host address width are not stored.
// - A written base takes effect only after the latch command.
// - Bit 11 selects table format: 0 regular, 1 extended.
// - Without extended support the format bit reads zero and is ignored.
// - Writing the top byte with bit 63 set launches a context flush.
// - On completion the request bit clears and performed scope is recorded.
// - With write-buffer flush needed, buffers are flushed before invalidating.
// - Scope encoding 01 global, 10 domain, 11 device; coarser allowed.
// - Performed scope bits 60:59 are read-only, updated at completion.
// - Latched status clears on latch command, sets once base is loaded.
// - Function mask bits 33:32 mask requester id function bits 2, 2:1, 2:0.
`timescale 1ns/10ps
`include "rpcf_regs.vh"
module rpcf_regbank #(
  parameter HOST_ADDR_W = 48          // Host address width, at most 64.
) (
  input  wire        clk_i,           // Clock, 250 MHz.
  input  wire        rst_n_i,         // Asynchronous reset, active low.
  input  wire [7:0]  addr_i,          // Register byte address.
  input  wire [31:0] wdata_i,         // Write data.
  input  wire        wr_i,            // Write strobe, one cycle.
  input  wire        rd_i,            // Read strobe, one cycle.
  output reg  [31:0] rdata_o,         // Read data, the cycle after the read strobe.
  input  wire        ext_support_i,   // Extended support capability, strap level.
  input  wire        wbuf_needed_i,   // Write-buffer flush needed capability.
  input  wire        trans_active_i,  // Translation active flag.
  input  wire        wbuf_done_i,     // Write-buffer flush done, one-cycle pulse.
  input  wire        flush_done_i,    // Context cache flush done, one-cycle pulse.
  input  wire [1:0]  flush_scope_i,   // Scope applied by the context cache.
  output reg  [63:0] root_base_o,     // Root table pointer in use.
  output reg         root_fmt_o,      // Table format in use, 1 extended.
  output reg         wbuf_start_o,    // Write-buffer flush start, one-cycle pulse.
  output reg         flush_start_o,   // Context flush start, one-cycle pulse.
  output reg  [1:0]  flush_scope_o,   // Requested flush scope.
  output reg  [15:0] flush_dom_o,     // Target domain of the flush.
  output reg  [15:0] flush_rid_o,     // Requester id of the flush.
  output reg  [2:0]  flush_fmask_o    // Function bits of requester id to ignore.
);

  ////////////////////////////////////////////////////////////////////////////
  // Constants and helper functions.

  localparam ST_IDLE  = 2'h0;
  localparam ST_WBUF  = 2'h1;
  localparam ST_FLUSH = 2'h2;

  localparam [63:0] BASE_MASK = ((HOST_ADDR_W >= 64) ? {64{1'b1}} :
                                 ((64'h1 << HOST_ADDR_W) - 64'h1))
                                & ~((64'h1 << `RPCF_RTP_BASE_LSB) - 64'h1);

  // Turns the two-bit function mask selector into a mask of ignored bits.
  function [2:0] fmask_dec;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    fmask_dec = 3'h0;
        2'h1:    fmask_dec = 3'h4;
        2'h2:    fmask_dec = 3'h6;
        default: fmask_dec = 3'h7;
      endcase
    end
  endfunction

  // Address match for a write strobe.
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Synchronise the two capability levels that come from other logic.

  wire [1:0] caps_s;

  rpcf_sync2 #(
    .W (2)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({ext_support_i, wbuf_needed_i}),
    .q_o     (caps_s)
  );

  wire ext_s  = caps_s[1];
  wire wbuf_s = caps_s[0];

  ////////////////////////////////////////////////////////////////////////////
  // Storage.

  reg [63:0] rtp_r;                   // Programmed root table pointer.
  reg        latched_r;               // Root pointer latched status.
  reg        latch_pend_r;            // Latch command waiting to load.
  reg        req_r;                   // Flush request bit.
  reg [1:0]  rscope_r;                // Requested scope.
  reg [1:0]  pscope_r;                // Performed scope.
  reg [31:0] lo_r;                    // Requester id and domain word.
  reg [1:0]  state_r;
  reg [1:0]  state_nxt;

  wire wr_rtp_lo = wr_i && hit(addr_i, `RPCF_RTP_LO_OFS);
  wire wr_rtp_hi = wr_i && hit(addr_i, `RPCF_RTP_HI_OFS);
  wire wr_cfc_lo = wr_i && hit(addr_i, `RPCF_CFC_LO_OFS);
  wire wr_cfc_hi = wr_i && hit(addr_i, `RPCF_CFC_HI_OFS);
  wire wr_gcmd   = wr_i && hit(addr_i, `RPCF_GCMD_OFS);
  wire latch_cmd = wr_gcmd && wdata_i[`RPCF_GCMD_LATCH_BIT];
  // Top byte written with the request bit set; ignored while busy.
  wire launch    = wr_cfc_hi && wdata_i[`RPCF_CFC_REQ_BIT] && !req_r;

  ////////////////////////////////////////////////////////////////////////////
  // Root table pointer register and latch handshake.

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rtp_r        <= {64{1'b0}};
      latched_r    <= 1'b0;
      latch_pend_r <= 1'b0;
      root_base_o  <= {64{1'b0}};
      root_fmt_o   <= 1'b0;
    end else begin
      if (wr_rtp_lo) begin
        // Base bits kept, format bit kept only with extended support, rest zero.
        rtp_r[31:0] <= wdata_i & BASE_MASK[31:0];
        rtp_r[`RPCF_RTP_FMT_BIT] <= wdata_i[`RPCF_RTP_FMT_BIT] & ext_s;
      end
      if (wr_rtp_hi) begin
        rtp_r[63:32] <= wdata_i & BASE_MASK[63:32];
      end
      if (latch_cmd) begin
        latched_r    <= 1'b0;
        latch_pend_r <= 1'b1;
      end else if (latch_pend_r) begin
        // The pointer goes into use only here, one cycle after the command.
        root_base_o  <= rtp_r & BASE_MASK;
        root_fmt_o   <= rtp_r[`RPCF_RTP_FMT_BIT] & ext_s;
        latched_r    <= 1'b1;
        latch_pend_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flush sequencer: optional write-buffer flush, then the context flush.

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (launch) begin
          state_nxt = wbuf_s ? ST_WBUF : ST_FLUSH;
        end
      end
      ST_WBUF: begin
        if (wbuf_done_i) begin
          state_nxt = ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        if (flush_done_i) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Command fields, start pulses and completion.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r       <= ST_IDLE;
      req_r         <= 1'b0;
      rscope_r      <= `RPCF_ZERO2;
      pscope_r      <= `RPCF_ZERO2;
      lo_r          <= `RPCF_ZERO32;
      wbuf_start_o  <= 1'b0;
      flush_start_o <= 1'b0;
      flush_scope_o <= `RPCF_ZERO2;
      flush_dom_o   <= 16'h0000;
      flush_rid_o   <= 16'h0000;
      flush_fmask_o <= 3'h0;
    end else begin
      state_r       <= state_nxt;
      wbuf_start_o  <= 1'b0;
      flush_start_o <= 1'b0;
      if (wr_cfc_lo && !req_r) begin
        lo_r <= wdata_i;
      end
      if (wr_cfc_hi && !req_r) begin
        rscope_r <= wdata_i[`RPCF_CFC_RSC_MSB:`RPCF_CFC_RSC_LSB];
      end
      if (launch) begin
        req_r         <= 1'b1;
        flush_scope_o <= wdata_i[`RPCF_CFC_RSC_MSB:`RPCF_CFC_RSC_LSB];
        flush_dom_o   <= lo_r[`RPCF_CFC_DOM_MSB:`RPCF_CFC_DOM_LSB];
        flush_rid_o   <= lo_r[`RPCF_CFC_RID_MSB:`RPCF_CFC_RID_LSB];
        flush_fmask_o <= fmask_dec(wdata_i[`RPCF_CFC_FMS_MSB:`RPCF_CFC_FMS_LSB]);
        if (wbuf_s) begin
          wbuf_start_o <= 1'b1;
        end else begin
          flush_start_o <= 1'b1;
        end
      end
      if (state_r == ST_WBUF && wbuf_done_i) begin
        flush_start_o <= 1'b1;
      end
      if (state_r == ST_FLUSH && flush_done_i) begin
        req_r    <= 1'b0;
        pscope_r <= flush_scope_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data stand in the cycle after the strobe, unmapped reads zero.

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= `RPCF_ZERO32;
    end else if (rd_i) begin
      case (addr_i)
        `RPCF_RTP_LO_OFS: rdata_o <= rtp_r[31:0];
        `RPCF_RTP_HI_OFS: rdata_o <= rtp_r[63:32];
        `RPCF_CFC_HI_OFS: rdata_o <= {req_r, rscope_r, pscope_r, 27'h0000000};
        `RPCF_GSTS_OFS:   rdata_o <= {1'b0, latched_r, 30'h00000000};
        default:          rdata_o <= `RPCF_ZERO32;
      endcase
    end else begin
      rdata_o <= `RPCF_ZERO32;
    end
  end

endmodule // rpcf_regbank

// *** bench/rpcf_regbank_asserts.sv ***
// Concurrent checks on the ports of the root pointer and context flush register bank.
`timescale 1ns/10ps
module rpcf_regbank_asserts #(
  parameter HOST_ADDR_W = 48                                  // Host address width.
) (
  input wire        clk_i, rst_n_i, wr_i, rd_i, wbuf_done_i,  // Clock, reset, strobes.
  input wire        wbuf_start_o, flush_start_o, root_fmt_o,  // Pulses and format in use.
  input wire [7:0]  addr_i,                                   // Byte address.
  input wire [31:0] wdata_i, rdata_o,                         // Bus data.
  input wire [63:0] root_base_o,                              // Pointer in use.
  input wire [1:0]  flush_scope_o,                            // Requested scope.
  input wire [2:0]  flush_fmask_o                             // Ignored requester id bits.
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Decoded launch and latch writes.
  wire launch_w = wr_i && addr_i == 8'h2c && wdata_i[31];
  wire latch_w  = wr_i && addr_i == 8'h30 && wdata_i[30];
  ////////////////////////////////////////////////////////////////////////////
  a_rdata_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data not zero outside a read");
  a_flush_has_cause: assert property (flush_start_o |-> $past(launch_w) || $past(wbuf_done_i))
    else $error("flush started without a launch write or buffer done");
  a_flush_one_pulse: assert property (flush_start_o |=> !flush_start_o)
    else $error("flush start longer than one cycle");
  a_wbuf_has_cause: assert property (wbuf_start_o |-> $past(launch_w))
    else $error("buffer flush started without a launch write");
  a_scope_passed: assert property (flush_start_o && $past(launch_w) |->
    flush_scope_o == $past(wdata_i[30:29])) else $error("requested scope not passed on");
  a_fmask_decoded: assert property (flush_start_o && $past(launch_w) |-> flush_fmask_o ==
    {$past(wdata_i[1:0]) != 2'h0, $past(wdata_i[1]), $past(wdata_i[1:0]) == 2'h3})
    else $error("function mask decoded wrongly");
  a_base_bits_masked: assert property (root_base_o[11:0] == 12'h0 &&
    (root_base_o >> HOST_ADDR_W) == 64'h0)
    else $error("pointer in use has bits outside the base field");
  a_base_on_latch: assert property ($changed({root_base_o, root_fmt_o}) |->
    $past(latch_w) || $past(latch_w, 2) || $past(latch_w, 3))
    else $error("pointer in use changed without a latch command");
  // Main scenarios.
  c_flush: cover property (flush_start_o && $past(launch_w));
  c_wbuf: cover property (wbuf_start_o);
  c_ext_fmt: cover property ($rose(root_fmt_o));
endmodule // rpcf_regbank_asserts

bind rpcf_regbank rpcf_regbank_asserts #(.HOST_ADDR_W(HOST_ADDR_W)) i_rpcf_regbank_asserts (
  .clk_i(clk_i),
  .rst_n_i(rst_n_i), .wr_i(wr_i), .rd_i(rd_i), .wbuf_done_i(wbuf_done_i), .addr_i(addr_i),
  .wbuf_start_o(wbuf_start_o), .flush_start_o(flush_start_o), .root_fmt_o(root_fmt_o),
  .wdata_i(wdata_i), .rdata_o(rdata_o), .root_base_o(root_base_o),
  .flush_scope_o(flush_scope_o), .flush_fmask_o(flush_fmask_o));

// *** bench/rpcf_cache_model.sv ***
// Behavioural model of the write buffer and context cache behind the register bank.
`timescale 1ns/10ps
module rpcf_cache_model (
  input  wire       clk_i,          // Clock.
  input  wire       rst_n_i,        // Reset, active low.
  input  wire       slow_i,         // Take forty cycles instead of two.
  input  wire       coarse_i,       // Apply global scope instead of the requested one.
  input  wire       wbuf_start_i,   // Write-buffer flush start.
  input  wire       flush_start_i,  // Context flush start.
  input  wire [1:0] scope_i,        // Requested scope.
  output reg        wbuf_done_o,    // Write-buffer flush done pulse.
  output reg        flush_done_o,   // Context flush done pulse.
  output wire [1:0] applied_o       // Applied scope, valid with the done pulse.
);
  reg [5:0] cnt_r;
  reg       is_wbuf_r;
  reg [1:0] applied_r;
  // Outside the done pulse the scope lines show the inverse, never a stale value.
  assign applied_o = flush_done_o ? applied_r : ~applied_r;
  // One job at a time: count down, then pulse the matching done line.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {cnt_r, is_wbuf_r, applied_r, wbuf_done_o, flush_done_o} <= 11'h0;
    end else begin
      wbuf_done_o <= is_wbuf_r && cnt_r == 6'h1;
      flush_done_o <= !is_wbuf_r && cnt_r == 6'h1;
      if (wbuf_start_i || flush_start_i) begin
        cnt_r <= slow_i ? 6'h28 : 6'h2;
        is_wbuf_r <= wbuf_start_i;
        applied_r <= coarse_i ? 2'h1 : scope_i;
      end else if (cnt_r != 6'h0) begin
        cnt_r <= cnt_r - 6'h1;
      end
    end
  end
endmodule // rpcf_cache_model

// *** bench/test_root_pointer_and_context_flush.sv ***
// Self-checking testbench of the root pointer and context flush register bank.
`timescale 1ns/10ps
module test_root_pointer_and_context_flush;
  localparam HOST_ADDR_W = 40;
  reg         clk_i, rst_n_i, wr_i, rd_i, ext_i, wbn_i, act_i, slow_i, coarse_i;
  reg  [7:0]  addr_i;
  reg  [31:0] wdata_i, lo_r, hi_r, got;
  reg  [63:0] use_r;
  reg  [1:0]  sc;
  wire [31:0] rdata_o;
  wire [63:0] base_o;
  wire        fmt_o, wbs_o, fls_o, wbd_w, fld_w;
  wire [1:0]  rsc_o, psc_w;
  wire [15:0] dom_o, rid_o;
  wire [2:0]  fm_o;
  integer     mismatches, n_checks, cyc, nfl, nwb, f0, w0, i, k;
  rpcf_regbank #(.HOST_ADDR_W(HOST_ADDR_W)) i_rpcf_regbank (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .ext_support_i(ext_i),
    .wbuf_needed_i(wbn_i), .trans_active_i(act_i), .wbuf_done_i(wbd_w), .flush_done_i(fld_w),
    .flush_scope_i(psc_w), .root_base_o(base_o), .root_fmt_o(fmt_o), .wbuf_start_o(wbs_o),
    .flush_start_o(fls_o), .flush_scope_o(rsc_o), .flush_dom_o(dom_o), .flush_rid_o(rid_o),
    .flush_fmask_o(fm_o));
  rpcf_cache_model i_rpcf_cache_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .slow_i(slow_i),
    .coarse_i(coarse_i), .wbuf_start_i(wbs_o), .flush_start_i(fls_o), .scope_i(rsc_o),
    .wbuf_done_o(wbd_w), .flush_done_o(fld_w), .applied_o(psc_w));
  ////////////////////////////////////////////////////////////////////////////
  // Clock of 4 ns.
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Count start pulses and cut a hung run short.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (fls_o === 1'b1) nfl <= nfl + 1;
    if (wbs_o === 1'b1) nwb <= nwb + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      wrap_up;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task cmp(input string what, input [63:0] exp, input [63:0] seen);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("Error %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // Register bus cycles; read data are taken in the cycle after the strobe.
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 got = rdata_o;
    end
  endtask
  task wrap_up;
    begin
      if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  // Expected pointer words: format bit only with extended support, high bits cut at HOST_ADDR_W.
  function [31:0] exp_lo(input [31:0] d, input e);
    exp_lo = {d[31:12], d[11] & e, 11'h0};
  endfunction
  function [31:0] exp_hi(input [31:0] d);
    exp_hi = d & ((32'h1 << (HOST_ADDR_W - 32)) - 32'h1);
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n_i, wr_i, rd_i, ext_i, wbn_i, act_i, slow_i, coarse_i, addr_i, wdata_i} = 48'h0;
    {mismatches, n_checks, cyc, nfl, nwb} = 160'h0;
    use_r = 64'h0;
    i = $urandom(32'h51aa);
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    // Pointer written, read back, held off until latched; last pass uses all ones.
    for (k = 0; k < 4; k = k + 1) begin
      ext_i <= k[0];
      // Translation is idle while the format bit may change.
      act_i <= 1'b0;
      lo_r = (k == 3) ? 32'hffffffff : $urandom;
      hi_r = (k == 3) ? 32'hffffffff : $urandom;
      repeat (3) @(posedge clk_i);
      wr(8'h20, lo_r);
      wr(8'h24, hi_r);
      rd(8'h20);
      cmp("pointer low", exp_lo(lo_r, k[0]), got);
      rd(8'h24);
      cmp("pointer high", exp_hi(hi_r), got);
      cmp("base before latch", use_r, base_o);
      wr(8'h30, 32'h40000000);
      repeat (3) @(posedge clk_i);
      use_r = {exp_hi(hi_r), lo_r[31:12], 12'h0};
      cmp("base in use", use_r, base_o);
      cmp("format in use", k[0] & lo_r[11], fmt_o);
      act_i <= $urandom;
      rd(8'h34);
      cmp("latched status", 32'h40000000, got);
    end
    // Flushes of every scope, with and without buffer flush, prompt and slow answers.
    for (k = 0; k < 8; k = k + 1) begin
      wbn_i <= k[2];
      slow_i <= k[0];
      coarse_i <= k[1];
      sc = (k % 3) + 1;
      lo_r = $urandom;
      hi_r = $urandom;
      hi_r[31:29] = {1'b1, sc};
      repeat (3) @(posedge clk_i);
      f0 = nfl;
      w0 = nwb;
      wr(8'h28, lo_r);
      wr(8'h2c, hi_r);
      #1;
      for (i = 0; i < 60 && fls_o !== 1'b1; i = i + 1) begin
        @(posedge clk_i);
        #1;
      end
      cmp("scope", sc, rsc_o);
      cmp("domain", lo_r[15:0], dom_o);
      cmp("requester", lo_r[31:16], rid_o);
      cmp("fmask", {hi_r[1:0] != 2'h0, hi_r[1], &hi_r[1:0]}, fm_o);
      wr(8'h2c, hi_r);
      got = 32'h80000000;
      for (i = 0; i < 30 && got[31]; i = i + 1) rd(8'h2c);
      cmp("flush status", {1'b0, sc, k[1] ? 2'h1 : sc, 27'h0}, got);
      cmp("flush count", f0 + 1, nfl);
      cmp("buffer count", w0 + k[2], nwb);
      // The cache invalidation that must follow a flush is outside this block.
      rd(8'h28);
      cmp("low command word", 32'h0, got);
    end
    // Stray write and read at an unmapped place.
    wr(8'h38, $urandom);
    rd(8'h3c);
    cmp("unmapped", 32'h0, got);
    rd(8'h24);
    cmp("pointer after stray", use_r[63:32], got);
    wrap_up;
  end
endmodule // test_root_pointer_and_context_flush
